/* File: src/sol_pkg.sv */
// Package with constants and types of the sixteen channel output latch
package sol_pkg;
	localparam int CHAN_COUNT = 16;
	localparam logic [15:0] STATE_RESET = 16'h0000;
	localparam logic [3:0] SIGN_BIT_POS = 4'hF;
	localparam logic [23:0] ID_FULL_DEFAULT = 24'hA5A501; // Arbitrary value
	localparam logic [23:0] ID_PARTIAL_DEFAULT = 24'hA5A500; // Arbitrary value
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_WORD_WRITE = 3'h1;
	localparam logic [2:0] CMD_SINGLE_CHANNEL_WRITE = 3'h2;
	localparam logic [2:0] CMD_RESET = 3'h3;
	localparam logic [2:0] CMD_WORD_READ = 3'h4;
	localparam logic [2:0] CMD_IDENTITY_QUERY = 3'h5;
	typedef enum logic [1:0] {
		SOL_ID_WAIT = 2'h0,
		SOL_ID_HELD = 2'h1
	} sol_id_state_t;
endpackage : sol_pkg

/* File: src/sol_cmd_if.sv */
// Interface carrying decoded write requests to the latch
`timescale 1ns/1ns
interface sol_cmd_if;
	logic word_we;
	logic [16:0] word_data;
	logic chan_we;
	logic [3:0] chan_sel;
	logic chan_val;
	logic clear;
	modport ctrl (output word_we, output word_data, output chan_we, output chan_sel,
		output chan_val, output clear);
	modport latch (input word_we, input word_data, input chan_we, input chan_sel,
		input chan_val, input clear);
endinterface : sol_cmd_if

/* File: src/sol_latch.sv */
// Sixteen bit channel state latch
`timescale 1ns/1ns
module sol_latch (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	sol_cmd_if.latch cmd,
	output logic [15:0] state_o
);
	logic [15:0] state_r;
	logic [15:0] state_nxt;

	// ****************************************
	// Per channel next state
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < sol_pkg::CHAN_COUNT; g++) begin : g_chan
			always_comb begin
				if (cmd.clear) begin
					state_nxt[g] = 1'b0;
				end else if (cmd.word_we) begin
					state_nxt[g] = cmd.word_data[g];
				end else if (cmd.chan_we && (cmd.chan_sel == 4'(g))) begin
					state_nxt[g] = cmd.chan_val;
				end else begin
					state_nxt[g] = state_r[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= sol_pkg::STATE_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign state_o = state_r;
endmodule : sol_latch

/* File: src/sol_top.sv */
// Top of the sixteen channel open drain output latch
`timescale 1ns/1ns
module sol_top #(
	parameter logic [23:0] ID_FULL = sol_pkg::ID_FULL_DEFAULT,
	parameter logic [23:0] ID_PARTIAL = sol_pkg::ID_PARTIAL_DEFAULT
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic cmd_valid_i,
	input wire logic [2:0] cmd_op_i,
	input wire logic [16:0] cmd_data_i,
	input wire logic [3:0] cmd_chan_i,
	input wire logic term_present_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output logic [16:0] rsp_data_o,
	output logic rsp_err_o,
	output logic [15:0] drain_oe_o,
	output logic [15:0] drain_o
);
	sol_cmd_if cmd_bus ();
	logic [15:0] state;
	sol_pkg::sol_id_state_t id_state_r;
	logic id_full_r;
	logic rsp_valid_r;
	logic [16:0] rsp_data_r;
	logic rsp_err_r;
	logic [16:0] word_in;
	logic word_in_ok;
	logic take;

	// ****************************************
	// Command decode
	// ****************************************
	assign take = cmd_valid_i;
	assign cmd_ready_o = 1'b1;
	// Data is 17-bit signed: accept -32768..65535
	always_comb begin
		word_in = cmd_data_i;
		word_in_ok = 1'b1;
		if (cmd_data_i[16] && !cmd_data_i[15]) begin
			word_in_ok = 1'b0;
		end
	end

	assign cmd_bus.word_we = take && (cmd_op_i == sol_pkg::CMD_WORD_WRITE) && word_in_ok;
	assign cmd_bus.word_data = word_in;
	assign cmd_bus.chan_we = take && (cmd_op_i == sol_pkg::CMD_SINGLE_CHANNEL_WRITE);
	assign cmd_bus.chan_sel = cmd_chan_i;
	assign cmd_bus.chan_val = |cmd_data_i;
	assign cmd_bus.clear = take && (cmd_op_i == sol_pkg::CMD_RESET);

	sol_latch u_latch (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.cmd(cmd_bus),
		.state_o(state)
	);

	// ****************************************
	// Identity capture
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			id_state_r <= sol_pkg::SOL_ID_WAIT;
			id_full_r <= 1'b0;
		end else begin
			unique case (id_state_r)
				sol_pkg::SOL_ID_WAIT: begin
					id_full_r <= term_present_i;
					id_state_r <= sol_pkg::SOL_ID_HELD;
				end
				sol_pkg::SOL_ID_HELD: begin
					id_full_r <= id_full_r;
				end
				default: begin
					id_state_r <= sol_pkg::SOL_ID_WAIT;
				end
			endcase
		end
	end

	// ****************************************
	// Responses
	// ****************************************
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rsp_valid_r <= 1'b0;
			rsp_data_r <= 17'h00000;
			rsp_err_r <= 1'b0;
		end else begin
			rsp_valid_r <= 1'b0;
			rsp_err_r <= 1'b0;
			if (take) begin
				unique case (cmd_op_i)
					sol_pkg::CMD_WORD_READ: begin
						rsp_valid_r <= 1'b1;
						// Sign extend from channel 15
						rsp_data_r <= {state[sol_pkg::SIGN_BIT_POS], state};
					end
					sol_pkg::CMD_IDENTITY_QUERY: begin
						rsp_valid_r <= 1'b1;
						rsp_data_r <= id_full_r ? ID_FULL[16:0] : ID_PARTIAL[16:0];
					end
					sol_pkg::CMD_WORD_WRITE: begin
						rsp_err_r <= !word_in_ok;
					end
					default: begin
						rsp_err_r <= (cmd_op_i > sol_pkg::CMD_IDENTITY_QUERY);
					end
				endcase
			end
		end
	end

	assign rsp_valid_o = rsp_valid_r;
	assign rsp_data_o = rsp_data_r;
	assign rsp_err_o = rsp_err_r;

	// ****************************************
	// Open drain pins
	// ****************************************
	assign drain_oe_o = state;
	assign drain_o = sol_pkg::STATE_RESET;
endmodule : sol_top

/* File: bench/sol_checker.sv */
// Port assertions of the output latch
`timescale 1ns/1ns
module sol_checker (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic cmd_valid_i,
	input wire logic [2:0] cmd_op_i,
	input wire logic [16:0] cmd_data_i,
	input wire logic [3:0] cmd_chan_i,
	input wire logic cmd_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [16:0] rsp_data_o,
	input wire logic rsp_err_o,
	input wire logic [15:0] drain_oe_o,
	input wire logic [15:0] drain_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	logic w, bad;
	assign w = cmd_valid_i && cmd_op_i == 3'h1;
	assign bad = cmd_data_i[16] && !cmd_data_i[15];
	a_word_write: assert property (w && !bad |=> drain_oe_o == $past(cmd_data_i[15:0]))
		else $error("word write");
	a_word_refuse: assert property (w && bad |=> rsp_err_o && $stable(drain_oe_o))
		else $error("word refuse");
	a_reset_cmd: assert property (cmd_valid_i && cmd_op_i == 3'h3 |=> drain_oe_o == 16'h0000)
		else $error("reset command");
	a_chan_write: assert property (cmd_valid_i && cmd_op_i == 3'h2
		|=> drain_oe_o[$past(cmd_chan_i)] == |$past(cmd_data_i)) else $error("channel write");
	a_read_back: assert property (cmd_valid_i && cmd_op_i == 3'h4
		|=> rsp_valid_o && rsp_data_o == {$past(drain_oe_o[15]), $past(drain_oe_o)})
		else $error("read back");
	a_id_answer: assert property (cmd_valid_i && cmd_op_i == 3'h5 |=> rsp_valid_o
		&& (rsp_data_o == sol_pkg::ID_FULL_DEFAULT[16:0]
		|| rsp_data_o == sol_pkg::ID_PARTIAL_DEFAULT[16:0]))
		else $error("identity answer");
	a_ready_high: assert property (cmd_ready_o)
		else $error("ready low");
	a_bad_op: assert property (cmd_valid_i && cmd_op_i > 3'h5
		|=> rsp_err_o && !rsp_valid_o && $stable(drain_oe_o))
		else $error("unknown opcode");
	a_state_hold: assert property (!cmd_valid_i |=> $stable(drain_oe_o))
		else $error("state hold");
	a_open_drain: assert property (drain_o == 16'h0000)
		else $error("drain level");
endmodule : sol_checker
bind sol_top sol_checker i_chk (.*);

/* File: bench/sol_host.sv */
// Host model issuing channel commands
`timescale 1ns/1ns
module sol_host (
	input wire logic clk_sys_i,
	input wire logic rdy_i,
	output logic v_o,
	output logic [2:0] op_o,
	output logic [16:0] d_o,
	output logic [3:0] ch_o
);
	initial {v_o, op_o, d_o, ch_o} = 25'h0000000;
	task issue(input logic [2:0] op, input logic [16:0] d, input logic [3:0] ch);
		// Called 1 ns after an edge; returns 1 ns after the taking edge
		{v_o, op_o, d_o, ch_o} = {1'b1, op, d, ch};
		@(posedge clk_sys_i);
		while (rdy_i !== 1'b1) @(posedge clk_sys_i);
		#1;
	endtask : issue
	task idle;
		v_o = 1'b0;
		@(posedge clk_sys_i);
		#1;
	endtask : idle
endmodule : sol_host

/* File: bench/test_sol_top.sv */
// Self-checking testbench of the output latch
`timescale 1ns/1ns
module test_sol_top;
	typedef struct {logic [2:0] op; logic [16:0] d; logic [3:0] ch; logic [15:0] e;} sol_row_t;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic term = 1'b1;
	logic v, re, rv, rdy;
	logic [2:0] op;
	logic [16:0] d, rd;
	logic [3:0] ch;
	logic [15:0] oe;
	int err_total = 0;
	int n_tests = 0;
	sol_row_t rows [6] = '{'{3'h1, 17'h1FFFF, 4'h0, 16'hFFFF}, '{3'h2, 17'h00000, 4'hF, 16'h7FFF},
		'{3'h1, 17'h0FFFF, 4'h0, 16'hFFFF}, '{3'h1, 17'h00254, 4'h0, 16'h0254},
		'{3'h2, 17'h00008, 4'h0, 16'h0255}, '{3'h1, 17'h18000, 4'h0, 16'h8000}};
	always #20 clk_sys_i = ~clk_sys_i;
	sol_host h (.clk_sys_i(clk_sys_i), .rdy_i(rdy), .v_o(v), .op_o(op), .d_o(d), .ch_o(ch));
	sol_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(v), .cmd_op_i(op),
		.cmd_data_i(d), .cmd_chan_i(ch), .term_present_i(term), .cmd_ready_o(rdy),
		.rsp_valid_o(rv), .rsp_data_o(rd), .rsp_err_o(re), .drain_oe_o(oe), .drain_o());
	task chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask : chk_bit
	task chk(input logic [16:0] g, input logic [16:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: %h expected %h", $time, g, e);
		end
	endtask : chk
	task stop_test;
		$display("errors %0d tests %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		repeat (4) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		foreach (rows[i]) begin
			h.issue(rows[i].op, rows[i].d, rows[i].ch);
			chk({1'b0, oe}, {1'b0, rows[i].e});
		end
		term = 1'b0;
		h.issue(3'h1, 17'h10000, 4'h0);
		chk_bit(re, 1'h1);
		chk({1'b0, oe}, 17'h08000);
		h.issue(3'h4, 17'h00000, 4'h0);
		chk_bit(rv, 1'h1);
		chk(rd, 17'h18000);
		h.issue(3'h7, 17'h0FFFF, 4'h0);
		chk_bit(re, 1'h1);
		chk({1'b0, oe}, 17'h08000);
		h.issue(3'h5, 17'h00000, 4'h0);
		chk_bit(rv, 1'h1);
		chk(rd, sol_pkg::ID_FULL_DEFAULT[16:0]);
		h.issue(3'h3, 17'h00000, 4'h0);
		chk_bit(rv, 1'h0);
		chk({1'b0, oe}, 17'h00000);
		chk_bit(rdy, 1'h1);
		h.issue(3'h1, 17'h00001, 4'h0);
		chk({1'b0, oe}, 17'h00001);
		h.idle();
		nrst_i = 1'b0;
		@(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		chk({1'b0, oe}, 17'h00000);
		@(posedge clk_sys_i);
		#1;
		h.issue(3'h5, 17'h00000, 4'h0);
		chk(rd, sol_pkg::ID_PARTIAL_DEFAULT[16:0]);
		stop_test();
	end
	initial begin
		#20000;
		err_total++;
		stop_test();
	end
endmodule : test_sol_top
